// [design/pcg_clock_unit.sv]
// Loop clock generation unit: dividers, lock detector, bus and timer clock ticks
//
// Contract
// - With the crystal disabled the internal 1.024 MHz RC clock is the loop reference.
// - With the crystal enabled the reference is crystal clock over divider plus one.
// - Core clock is twice reference times multiplier plus one, factors 2 to 128.
// - While locked, output clock is core clock over output divider plus one.
// - While unlocked, output clock is core clock over four.
// - With the bus source on the loop, bus clock is half the output clock.
// - Read-only lock bit sets inside lock tolerance, clears outside unlock tolerance.
// - With the enable set, every lock bit toggle raises an interrupt request.
// - Halted watchdog on auxiliary clock restarts two auxiliary cycles after stop exit.
// - After reset: internal reference mode, 51.2 MHz core, output divider 0x03.
// - Watchdog and tick timer clocks select internal reference or auxiliary RC.
// - Loss of lock also clears the crystal stable flag.
`timescale 1ns/100ps
`include "pcg_defs.svh"

module pcg_clock_unit
(
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_internal_rc_clock,
  input  wire logic                       i_crystal_clock,
  input  wire logic                       i_aux_rc_clock,
  input  wire logic                       i_core_clock,
  input  wire logic                       i_crystal_ready,
  input  wire logic                       i_cfg_write,
  input  wire logic                       i_crystal_enable,
  input  wire logic [`PCG_REFERENCE_DIVIDER_W-1:0]   i_reference_divider,
  input  wire logic [`PCG_MULT_W-1:0]     i_feedback_multiplier,
  input  wire logic [`PCG_POST_W-1:0]     i_output_divider,
  input  wire logic [`PCG_RANGE_W-1:0]    i_reference_range_select,
  input  wire logic [`PCG_RANGE_W-1:0]    i_core_range_select,
  input  wire logic                       i_bus_source_select,
  input  wire logic                       i_tolerance_change_irq_enable,
  input  wire logic                       i_lock_flag_clear,
  input  wire logic                       i_watchdog_source_aux,
  input  wire logic                       i_timer_source_aux,
  input  wire logic                       i_watchdog_stop_halt,
  input  wire logic                       i_stop_mode,
  output logic                            o_loop_reference_tick,
  output logic                            o_loop_output_tick,
  output logic                            o_bus_tick,
  output pcg_pkg::pcg_lock_e              o_lock_state,
  output logic                            o_lock,
  output logic                            o_lock_flag,
  output logic                            o_lock_irq,
  output logic                            o_crystal_stable_flag,
  output logic                            o_watchdog_tick,
  output logic                            o_timer_tick,
  output logic                            o_watchdog_run,
  output logic                            o_stop_allowed,
  output logic [7:0]                      o_core_multiplier,
  output logic [5:0]                      o_output_ratio,
  output logic [4:0]                      o_reference_ratio,
  output logic [`PCG_RANGE_W-1:0]         o_reference_range_select,
  output logic [`PCG_RANGE_W-1:0]         o_core_range_select,
  output logic                            o_bus_source_select
);
  import pcg_pkg::*;

  function automatic logic [5:0] next_count(input logic [5:0] cnt, input logic [5:0] lim);
    next_count = (cnt >= lim) ? 6'h00 : cnt + 6'h01;
  endfunction

  function automatic pcg_cnt_t abs_diff(input pcg_cnt_t a, input pcg_cnt_t b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and rising edges
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  wire  [4:0] pins = {i_crystal_ready, i_core_clock, i_aux_rc_clock,
                      i_crystal_clock, i_internal_rc_clock};

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire irc_edge   = sync2[0] & ~sync3[0];
  wire xtal_edge  = sync2[1] & ~sync3[1];
  wire aux_edge   = sync2[2] & ~sync3[2];
  wire core_edge  = sync2[3] & ~sync3[3];
  wire xtal_ready = sync2[4];

  //////////////////////////////////////////////////////////////////////////////
  // Configuration, loaded on a write strobe
  logic                     xtal_en;
  logic [`PCG_REFERENCE_DIVIDER_W-1:0] ref_div;
  logic [`PCG_MULT_W-1:0]   mult;
  logic [`PCG_POST_W-1:0]   post;
  logic [`PCG_RANGE_W-1:0]  ref_range;
  logic [`PCG_RANGE_W-1:0]  core_range;
  logic                     bus_sel;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      xtal_en    <= 1'b0;
      ref_div    <= `PCG_RST_REFERENCE_DIVIDER;
      mult       <= `PCG_RST_MULT;
      post       <= `PCG_RST_POST;
      ref_range  <= `PCG_RST_REFRANGE;
      core_range <= `PCG_RST_CORERANGE;
      bus_sel    <= `PCG_RST_BUS_SEL;
    end
    else if (i_cfg_write)
    begin
      xtal_en    <= i_crystal_enable;
      ref_div    <= i_reference_divider;
      mult       <= i_feedback_multiplier;
      post       <= i_output_divider;
      ref_range  <= i_reference_range_select;
      core_range <= i_core_range_select;
      bus_sel    <= i_bus_source_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference, feedback and output dividers
  logic [5:0] ref_cnt;
  logic [5:0] fb_cnt;
  logic [5:0] out_cnt;
  logic       bus_phase;
  logic       locked;

  wire        xtal_ref_hit = xtal_edge & (ref_cnt >= {2'h0, ref_div});
  wire        ref_tick     = xtal_en ? xtal_ref_hit : irc_edge;
  wire        fb_tick      = core_edge & (fb_cnt >= mult);
  wire [4:0]  post_lim     = locked ? post : `PCG_UNLOCK_POST;
  wire        out_tick     = core_edge & (out_cnt >= {1'b0, post_lim});
  wire        next_bus     = bus_sel ? (out_tick & bus_phase) : xtal_edge;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ref_cnt   <= 6'h00;
      fb_cnt    <= 6'h00;
      out_cnt   <= 6'h00;
      bus_phase <= 1'b0;
    end
    else
    begin
      // Restart reference and output dividers when a limit changes so no count runs past it
      if (i_cfg_write)
        ref_cnt <= 6'h00;
      else if (xtal_edge)
        ref_cnt <= next_count(ref_cnt, {2'h0, ref_div});
      if (core_edge)
        fb_cnt <= next_count(fb_cnt, mult);
      if (i_cfg_write || lock_change)
        out_cnt <= 6'h00;
      else if (core_edge)
        out_cnt <= next_count(out_cnt, {1'b0, post_lim});
      if (out_tick)
        bus_phase <= ~bus_phase;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock detector: feedback ticks per window against twice the window
  logic [7:0] win_cnt;
  pcg_cnt_t   fb_seen;
  pcg_lock_e  lock_state;
  pcg_lock_e  next_lock;

  wire        win_end  = ref_tick & (win_cnt == `PCG_LOCK_WIN - 8'h01);
  wire pcg_cnt_t expect_fb = {`PCG_LOCK_WIN, 1'b0};
  wire pcg_cnt_t fb_total  = fb_seen + {8'h00, fb_tick};
  wire pcg_cnt_t fb_err    = abs_diff(fb_total, expect_fb);

  always_comb
  begin
    next_lock = lock_state;
    case (lock_state)
      PCG_UNLOCKED:
        if (win_end && fb_err <= `PCG_LOCK_TOL)
          next_lock = PCG_LOCKED;
      PCG_LOCKED:
        if (win_end && fb_err > `PCG_UNL_TOL)
          next_lock = PCG_UNLOCKED;
      default:
        next_lock = PCG_UNLOCKED;
    endcase
  end

  assign locked = (lock_state == PCG_LOCKED);
  wire lock_change = (next_lock != lock_state);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      win_cnt    <= 8'h00;
      fb_seen    <= 9'h000;
      lock_state <= PCG_UNLOCKED;
    end
    else
    begin
      lock_state <= next_lock;
      if (win_end)
      begin
        win_cnt <= 8'h00;
        fb_seen <= 9'h000;
      end
      else
      begin
        if (ref_tick)
          win_cnt <= win_cnt + 8'h01;
        fb_seen <= fb_total;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock change flag, interrupt and crystal stable flag
  logic lock_flag;
  logic xtal_stable;

  wire next_flag   = lock_change | (lock_flag & ~i_lock_flag_clear);
  wire next_stable = xtal_en & xtal_ready & ~(lock_change & locked)
                     & (xtal_stable | locked);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      lock_flag   <= 1'b0;
      xtal_stable <= 1'b0;
    end
    else
    begin
      lock_flag   <= next_flag;
      xtal_stable <= next_stable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog and tick timer clocks with stop-exit restart delay
  logic       stop_d;
  logic [1:0] restart_cnt;
  logic       wdog_run;

  wire halt_aux  = i_watchdog_source_aux & i_watchdog_stop_halt;
  wire stop_exit = stop_d & ~i_stop_mode;
  wire wdog_src  = i_watchdog_source_aux ? aux_edge : irc_edge;
  wire tmr_src   = i_timer_source_aux ? aux_edge : irc_edge;
  wire restart_done = aux_edge & (restart_cnt == `PCG_WDOG_RESTART - 2'h1);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      stop_d      <= 1'b0;
      restart_cnt <= 2'h0;
      wdog_run    <= 1'b1;
    end
    else
    begin
      stop_d <= i_stop_mode;
      if (i_stop_mode & halt_aux)
        wdog_run <= 1'b0;
      else if (stop_exit & halt_aux)
      begin
        wdog_run    <= 1'b0;
        restart_cnt <= 2'h0;
      end
      else if (!wdog_run && !i_stop_mode)
      begin
        if (restart_done)
          wdog_run <= 1'b1;
        else if (aux_edge)
          restart_cnt <= restart_cnt + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_loop_reference_tick <= 1'b0;
      o_loop_output_tick    <= 1'b0;
      o_bus_tick            <= 1'b0;
      o_lock_state          <= PCG_UNLOCKED;
      o_lock                <= 1'b0;
      o_lock_flag           <= 1'b0;
      o_lock_irq            <= 1'b0;
      o_crystal_stable_flag <= 1'b0;
      o_watchdog_tick       <= 1'b0;
      o_timer_tick          <= 1'b0;
      o_watchdog_run        <= 1'b1;
      o_stop_allowed        <= 1'b1;
      o_core_multiplier     <= 8'h32;
      o_output_ratio        <= 6'h04;
      o_reference_ratio     <= 5'h01;
      o_reference_range_select <= `PCG_RST_REFRANGE;
      o_core_range_select   <= `PCG_RST_CORERANGE;
      o_bus_source_select   <= `PCG_RST_BUS_SEL;
    end
    else
    begin
      o_loop_reference_tick <= ref_tick;
      o_loop_output_tick    <= out_tick;
      o_bus_tick            <= next_bus;
      o_lock_state          <= lock_state;
      o_lock                <= locked;
      o_lock_flag           <= lock_flag;
      o_lock_irq            <= lock_flag & i_tolerance_change_irq_enable;
      o_crystal_stable_flag <= xtal_stable;
      o_watchdog_tick       <= wdog_src & wdog_run;
      o_timer_tick          <= tmr_src;
      o_watchdog_run        <= wdog_run;
      o_stop_allowed        <= wdog_run | ~halt_aux;
      o_core_multiplier     <= {1'b0, mult, 1'b0} + 8'h02;
      o_output_ratio        <= {1'b0, post_lim} + 6'h01;
      o_reference_ratio     <= xtal_en ? {1'b0, ref_div} + 5'h01 : 5'h01;
      o_reference_range_select <= ref_range;
      o_core_range_select   <= core_range;
      o_bus_source_select   <= bus_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  ref_irc_a: assert property (!xtal_en && irc_edge |=> o_loop_reference_tick)
    else $error("internal reference tick missing");
  ref_div_a: assert property (xtal_en && ref_tick |-> ref_cnt == {2'h0, ref_div})
    else $error("reference divider ratio wrong");
  mult_out_a: assert property (1'b1 |=> o_core_multiplier == 2 * ($past(mult) + 1))
    else $error("core multiplier wrong");
  post_lock_a: assert property (locked && out_tick |-> out_cnt == {1'b0, post})
    else $error("locked output divider wrong");
  post_unlock_a: assert property (!locked && out_tick |-> out_cnt == 6'h03)
    else $error("unlocked output divide not four");
  bus_half_a: assert property (bus_sel && out_tick && bus_phase |=> o_bus_tick)
    else $error("bus tick not half output");
  flag_set_a: assert property (lock_change |=> lock_flag)
    else $error("lock change flag lost");
  irq_follow_a: assert property (lock_change && i_tolerance_change_irq_enable
                                 |=> ##1 o_lock_irq)
    else $error("lock interrupt missing");
  stable_drop_a: assert property ($fell(locked) |-> !xtal_stable)
    else $error("stable flag kept after lock loss");
  restart_a: assert property (stop_exit && halt_aux |=> !wdog_run)
    else $error("watchdog restarted early");

  lock_seen_c: cover property ($rose(locked));
  unlock_seen_c: cover property ($fell(locked));
  restart_c: cover property (!wdog_run ##1 wdog_run);
endmodule

// [design/pcg_defs.svh]
// Constants for the loop clock generation unit
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

// Clock rates in kHz
`define PCG_CLK_KHZ        20000
`define PCG_IRC_KHZ        1024

// Field widths
`define PCG_REFERENCE_DIVIDER_W       4
`define PCG_MULT_W         6
`define PCG_POST_W         5
`define PCG_RANGE_W        2

// Reset values of the internal-reference loop mode
`define PCG_RST_REFERENCE_DIVIDER     4'h0
`define PCG_RST_MULT       6'h18
`define PCG_RST_POST       5'h03
`define PCG_RST_REFRANGE   2'h0
`define PCG_RST_CORERANGE  2'h1
`define PCG_RST_BUS_SEL    1'b1

// Fixed divide while unlocked, minus one
`define PCG_UNLOCK_POST    5'h03

// Lock detector: window in reference ticks, tolerances in feedback ticks
`define PCG_LOCK_WIN       8'h08
`define PCG_LOCK_TOL       9'h001
`define PCG_UNL_TOL        9'h003

// Auxiliary cycles before the watchdog restarts after stop
`define PCG_WDOG_RESTART   2'h2

`endif

// [design/pcg_pkg.sv]
// Types for the loop clock generation unit
package pcg_pkg;
  typedef enum logic [1:0]
  {
    PCG_UNLOCKED = 2'h0,
    PCG_LOCKED   = 2'h1
  } pcg_lock_e;
  typedef logic [8:0] pcg_cnt_t;
endpackage

// [sim/pll_clock_generation_test.sv]
// Self-checking bench for the loop clock generation unit
`timescale 1ns/100ps
`include "pcg_defs.svh"

module pll_clock_generation_test;
  import pcg_pkg::*;

  typedef struct {int kind; logic [31:0] exp;} pcg_note_s;

  logic i_clk = 1'b0, i_rst_n = 1'b0, ref_pin = 1'b0, core_pin = 1'b0, aux_pin = 1'b0;
  logic i_crystal_ready = 1'b0, i_cfg_write = 1'b0, i_crystal_enable = 1'b0;
  logic [3:0] i_reference_divider = 4'h0;
  logic [5:0] i_feedback_multiplier = 6'h18;
  logic [4:0] i_output_divider = 5'h03;
  logic [1:0] i_reference_range_select = 2'h0, i_core_range_select = 2'h1;
  logic i_bus_source_select = 1'b1, i_tolerance_change_irq_enable = 1'b0;
  logic i_lock_flag_clear = 1'b0, i_watchdog_source_aux = 1'b0, i_timer_source_aux = 1'b0;
  logic i_watchdog_stop_halt = 1'b0, i_stop_mode = 1'b0, core_run = 1'b0;
  logic o_loop_reference_tick, o_loop_output_tick, o_bus_tick, o_lock, o_lock_flag;
  logic o_lock_irq, o_crystal_stable_flag, o_watchdog_tick, o_timer_tick, o_watchdog_run;
  logic o_stop_allowed, o_bus_source_select;
  pcg_lock_e o_lock_state;
  logic [7:0] o_core_multiplier;
  logic [5:0] o_output_ratio;
  logic [4:0] o_reference_ratio;
  logic [1:0] o_reference_range_select, o_core_range_select;
  pcg_note_s notes[$];
  pcg_note_s cur;
  logic [31:0] got, rnd;
  integer seed = 83285;
  int n_fail = 0, compares = 0, cycles = 0, phase = 0, c0, b0;
  int out_cnt = 0, bus_cnt = 0, wd_cnt = 0, tm_cnt = 0, rf_cnt = 0;

  pcg_clock_unit dut
  (
    .i_clk, .i_rst_n, .i_internal_rc_clock(ref_pin), .i_crystal_clock(ref_pin),
    .i_aux_rc_clock(aux_pin), .i_core_clock(core_pin), .i_crystal_ready, .i_cfg_write,
    .i_crystal_enable, .i_reference_divider, .i_feedback_multiplier, .i_output_divider,
    .i_reference_range_select, .i_core_range_select, .i_bus_source_select,
    .i_tolerance_change_irq_enable, .i_lock_flag_clear, .i_watchdog_source_aux,
    .i_timer_source_aux, .i_watchdog_stop_halt, .i_stop_mode, .o_loop_reference_tick,
    .o_loop_output_tick, .o_bus_tick, .o_lock_state, .o_lock, .o_lock_flag, .o_lock_irq,
    .o_crystal_stable_flag, .o_watchdog_tick, .o_timer_tick, .o_watchdog_run,
    .o_stop_allowed, .o_core_multiplier, .o_output_ratio, .o_reference_ratio,
    .o_reference_range_select, .o_core_range_select, .o_bus_source_select
  );

  always #25 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin clocks: reference 8 cycles, core 4 cycles while running, auxiliary 6
  always @(negedge i_clk)
  begin
    phase <= phase + 1;
    if (phase % 4 == 3)
      ref_pin <= ~ref_pin;
    if (core_run && phase % 2 == 1)
      core_pin <= ~core_pin;
    if (phase % 3 == 2)
      aux_pin <= ~aux_pin;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    out_cnt += int'(o_loop_output_tick === 1'b1);
    bus_cnt += int'(o_bus_tick === 1'b1);
    wd_cnt += int'(o_watchdog_tick === 1'b1);
    tm_cnt += int'(o_timer_tick === 1'b1);
    rf_cnt += int'(o_loop_reference_tick === 1'b1);
    if (cycles == 20000)
    begin
      $display("mismatch at %0t: run took too long", $time);
      n_fail++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result watcher: settles after the falling edge, then takes the oldest notes
  function automatic logic [31:0] observe(input int kind);
    case (kind)
      0: observe = {24'h0, o_core_multiplier};
      1: observe = {26'h0, o_output_ratio};
      2: observe = {27'h0, o_reference_ratio};
      3: observe = {31'h0, o_lock};
      4: observe = {31'h0, o_lock_flag};
      5: observe = {31'h0, o_lock_irq};
      6: observe = {31'h0, o_crystal_stable_flag};
      7: observe = {31'h0, o_watchdog_run};
      8: observe = {31'h0, o_stop_allowed};
      9: observe = {30'h0, o_lock_state};
      10: observe = {28'h0, o_reference_range_select, o_core_range_select};
      11: observe = {31'h0, o_bus_source_select};
      12: observe = 32'(out_cnt);
      13: observe = 32'(bus_cnt);
      14: observe = 32'(wd_cnt);
      15: observe = 32'(tm_cnt);
      default: observe = 32'(rf_cnt);
    endcase
  endfunction

  always @(negedge i_clk)
  begin
    #5;
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      got = observe(cur.kind);
      compares++;
      // Tick counts other than the watchdog count allow one tick of edge alignment slack
      if ((cur.kind == 12 || cur.kind == 13 || cur.kind >= 15) ?
          (got + 1 < cur.exp || got > cur.exp + 1) : (got !== cur.exp))
      begin
        $display("mismatch at %0t: kind %0d got %0h exp %0h", $time, cur.kind, got, cur.exp);
        n_fail++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic note(input int kind, input logic [31:0] exp);
    notes.push_back('{kind, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic cfg(input logic [31:0] v);
    i_crystal_enable = v[0];
    i_reference_divider = v[4:1];
    i_feedback_multiplier = v[10:5];
    i_output_divider = v[15:11];
    i_reference_range_select = v[17:16];
    i_core_range_select = v[19:18];
    i_bus_source_select = v[20];
    i_cfg_write = 1'b1;
    tick(1);
    i_cfg_write = 1'b0;
    tick(1);
  endtask

  task automatic wait_for(input int kind, input logic [31:0] val, input int max);
    int i;
    i = 0;
    while (observe(kind) !== val && i < max)
    begin
      tick(1);
      i++;
    end
    if (observe(kind) !== val)
    begin
      $display("mismatch at %0t: wait on kind %0d ran out", $time, kind);
      n_fail++;
    end
  endtask

  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge i_clk);
    tick(1);
    i_rst_n = 1'b1;
    tick(1);
    note(0, 32'h32);
    note(1, 32'h4);
    note(2, 32'h1);
    note(10, 32'h1);
    note(11, 32'h1);
    note(3, 32'h0);
    note(4, 32'h0);
    note(7, 32'h1);
    // Unlocked reconfiguration with random fields, first pass with crystal on and top reference divider and multiplier
    for (int k = 0; k < 6; k++)
    begin
      rnd = $random(seed);
      if (k == 0)
        rnd[10:0] = 11'h7ff;
      cfg(rnd);
      note(0, 32'(2 * (int'(rnd[10:5]) + 1)));
      note(2, rnd[0] ? 32'(int'(rnd[4:1]) + 1) : 32'h1);
      note(1, 32'h4);
      note(10, {28'h0, rnd[17:16], rnd[19:18]});
      note(11, {31'h0, rnd[20]});
    end
    // Lock with multiplier 0 and output divider 1
    cfg(32'h00100800);
    i_tolerance_change_irq_enable = 1'b1;
    core_run = 1'b1;
    wait_for(3, 32'h1, 800);
    tick(2);
    note(9, 32'(PCG_LOCKED));
    note(1, 32'h2);
    note(0, 32'h2);
    note(4, 32'h1);
    note(5, 32'h1);
    i_lock_flag_clear = 1'b1;
    tick(1);
    i_lock_flag_clear = 1'b0;
    tick(3);
    note(4, 32'h0);
    note(5, 32'h0);
    c0 = out_cnt;
    b0 = bus_cnt;
    tick(400);
    note(12, 32'(c0 + 50));
    note(13, 32'(b0 + 25));
    cfg(32'h00000800);
    b0 = bus_cnt;
    tick(400);
    note(11, 32'h0);
    note(13, 32'(b0 + 50));
    // Crystal as reference, then loss of lock
    i_crystal_ready = 1'b1;
    cfg(32'h00100801);
    wait_for(6, 32'h1, 800);
    i_tolerance_change_irq_enable = 1'b0;
    core_run = 1'b0;
    wait_for(3, 32'h0, 800);
    tick(2);
    note(6, 32'h0);
    note(1, 32'h4);
    note(9, 32'(PCG_UNLOCKED));
    note(4, 32'h1);
    note(5, 32'h0);
    i_tolerance_change_irq_enable = 1'b1;
    tick(2);
    note(5, 32'h1);
    i_tolerance_change_irq_enable = 1'b0;
    // Timer tick source: internal reference, then auxiliary
    c0 = tm_cnt;
    b0 = rf_cnt;
    tick(240);
    note(15, 32'(c0 + 30));
    note(16, 32'(b0 + 30));
    i_timer_source_aux = 1'b1;
    tick(10);
    c0 = tm_cnt;
    tick(240);
    note(15, 32'(c0 + 40));
    // Watchdog halted in stop, restart after stop exit
    i_watchdog_source_aux = 1'b1;
    i_watchdog_stop_halt = 1'b1;
    tick(10);
    i_stop_mode = 1'b1;
    tick(10);
    note(7, 32'h0);
    c0 = wd_cnt;
    tick(30);
    note(14, 32'(c0));
    i_stop_mode = 1'b0;
    tick(4);
    note(7, 32'h0);
    note(8, 32'h0);
    tick(40);
    note(7, 32'h1);
    note(8, 32'h1);
    tick(3);
    end_sim();
  end
endmodule
